// ===== epio_cfg.svh
// register offsets, reset values and field positions for the port five/six block
`ifndef EPIO_CFG_SVH
`define EPIO_CFG_SVH
`define EPIO_ADDR_W 16
`define EPIO_OFF_P5_LATCH 16'hffd8
`define EPIO_OFF_P6_LATCH 16'hffd9
`define EPIO_OFF_P5_DIR 16'hffe8
`define EPIO_OFF_P6_DIR 16'hffe9
`define EPIO_OFF_P5_PULLUP 16'hffef
`define EPIO_OFF_PWR_MODE 16'hfff0
`define EPIO_RST_BYTE 8'h00
`define EPIO_WO_READ 8'hff
`define EPIO_BIT_TIMER 6
`define EPIO_BIT_ADTRIG 5
`define EPIO_PWR_W 2
`endif

// ===== epio_pkg.sv
// types shared by the port five/six block
package epio_pkg;
  typedef enum logic [2:0] {
    EPIO_PWR_RUN = 3'b001,
    EPIO_PWR_HOLD = 3'b010,
    EPIO_PWR_OFF = 3'b100
  } epio_pwr_e;
  typedef logic [7:0] epio_byte_t;
endpackage : epio_pkg

// ===== epio_ports.sv
// two eight-bit general-purpose io ports with avalon-mm register access
//
// How it works
// [RULE1] port five pin: input at 0, output at 1
// [RULE2] port five bit six feeds timer input
// [RULE3] port five bit five feeds converter trigger
// [RULE4] pins float, hold or run by power mode
// [RULE5] pulled-up pins present high when floated
// [RULE6] pull-up only on input pins with enable
// [RULE7] pull-ups off after reset
// [RULE8] port six latch: eight read/write bits
// [RULE9] port six output bit reads latch
// [RULE10] port six input bit reads pad
// [RULE11] reset clears port six latch
// [RULE12] port six direction one drives pin
// [RULE13] port six direction reads all ones
// [RULE14] reset clears port six direction
// [RULE15] port five reads latch or pad by direction
// [RULE16] port five direction write-only, reset zero
// [RULE17] per-pin enable, data, pull-up; inputs synchronised
// [RULE18] power mode selects run, hold or float
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "epio_cfg.svh"
module epio_ports
  import epio_pkg::*;
#(
  parameter int PINS = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [`EPIO_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // power mode: 0 run, 1 hold, 2 float
  input wire logic [`EPIO_PWR_W-1:0] pwr_mode,
  // port five pads
  input wire logic [PINS-1:0] p5_pad_in,
  output logic [PINS-1:0] p5_pad_out,
  output logic [PINS-1:0] p5_pad_oe,
  output logic [PINS-1:0] p5_pad_pullup,
  // port six pads
  input wire logic [PINS-1:0] p6_pad_in,
  output logic [PINS-1:0] p6_pad_out,
  output logic [PINS-1:0] p6_pad_oe,
  // side functions of port five
  output logic [PINS-1:0] ext_irq_level,
  output logic timer_b_event_input,
  output logic converter_trigger_input
);
  initial
  begin
    if (PINS != 8)
    begin
      $error("epio_ports supports exactly eight pins per port");
    end
  end

  logic [PINS-1:0] port_five_latch_q;
  logic [PINS-1:0] port_five_direction_q;
  logic [PINS-1:0] port_five_pullup_enable_q;
  logic [PINS-1:0] port_six_latch_q;
  logic [PINS-1:0] port_six_direction_bits_q;
  epio_pwr_e pwr_q;
  logic [PINS-1:0] p5_level;
  logic [PINS-1:0] p6_level;
  logic [31:0] rdata_q;
  logic wait_q;
  logic [PINS-1:0] p5_out_q;
  logic [PINS-1:0] p5_oe_q;
  logic [PINS-1:0] p5_pu_q;
  logic [PINS-1:0] p6_out_q;
  logic [PINS-1:0] p6_oe_q;
  logic [PINS-1:0] irq_q;
  logic tmr_q;
  logic adt_q;
  logic wr_hit;
  logic rd_hit;
  logic [PINS-1:0] p5_pu_d;
  logic [31:0] rdata_d;
  epio_pwr_e pwr_d;

  // pad inputs cross into clk before any reader sees them
  epio_sync #(.WIDTH(PINS)) u_sync5 (
    .clk(clk),
    .reset_n(reset_n),
    .pad_in(p5_pad_in),
    .level(p5_level)
  );
  epio_sync #(.WIDTH(PINS)) u_sync6 (
    .clk(clk),
    .reset_n(reset_n),
    .pad_in(p6_pad_in),
    .level(p6_level)
  );

  // one wait cycle per access: request taken while waitrequest is low
  assign wr_hit = avs_write && !wait_q;
  assign rd_hit = avs_read && !wait_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_q <= 1'b1;
    end
    else if ((avs_read || avs_write) && wait_q)
    begin
      wait_q <= 1'b0;
    end
    else
    begin
      wait_q <= 1'b1;
    end
  end

  // port five registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      port_five_latch_q <= `EPIO_RST_BYTE;
      port_five_direction_q <= `EPIO_RST_BYTE; // RULE16
      port_five_pullup_enable_q <= `EPIO_RST_BYTE; // RULE7
    end
    else if (wr_hit && avs_byteenable[0])
    begin
      if (avs_address == `EPIO_OFF_P5_LATCH)
      begin
        port_five_latch_q <= avs_writedata[PINS-1:0];
      end
      if (avs_address == `EPIO_OFF_P5_DIR)
      begin
        port_five_direction_q <= avs_writedata[PINS-1:0];
      end
      if (avs_address == `EPIO_OFF_P5_PULLUP)
      begin
        port_five_pullup_enable_q <= avs_writedata[PINS-1:0];
      end
    end
  end

  // port six registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      port_six_latch_q <= `EPIO_RST_BYTE; // RULE11
      port_six_direction_bits_q <= `EPIO_RST_BYTE; // RULE14
    end
    else if (wr_hit && avs_byteenable[0])
    begin
      if (avs_address == `EPIO_OFF_P6_LATCH)
      begin
        port_six_latch_q <= avs_writedata[PINS-1:0]; // RULE8
      end
      if (avs_address == `EPIO_OFF_P6_DIR)
      begin
        port_six_direction_bits_q <= avs_writedata[PINS-1:0];
      end
    end
  end

  // power mode register; an illegal code falls back to float
  always_comb
  begin
    unique case (avs_writedata[`EPIO_PWR_W-1:0])
      2'h0: pwr_d = EPIO_PWR_RUN;
      2'h1: pwr_d = EPIO_PWR_HOLD;
      default: pwr_d = EPIO_PWR_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pwr_q <= EPIO_PWR_RUN;
    end
    else if (wr_hit && avs_byteenable[0] && avs_address == `EPIO_OFF_PWR_MODE)
    begin
      pwr_q <= pwr_d;
    end
  end

  // the power-mode pin and the register combine: either may ask for hold or float
  epio_pwr_e pwr_eff;
  always_comb
  begin
    if (pwr_mode == 2'h2 || pwr_mode == 2'h3 || pwr_q == EPIO_PWR_OFF)
    begin
      pwr_eff = EPIO_PWR_OFF;
    end
    else if (pwr_mode == 2'h1 || pwr_q == EPIO_PWR_HOLD)
    begin
      pwr_eff = EPIO_PWR_HOLD;
    end
    else
    begin
      pwr_eff = EPIO_PWR_RUN;
    end
  end

  // read mux
  always_comb
  begin
    rdata_d = 32'h0;
    unique case (avs_address)
      `EPIO_OFF_P5_LATCH:
        rdata_d[PINS-1:0] = (port_five_direction_q & port_five_latch_q)
                          | (~port_five_direction_q & p5_level); // RULE15
      `EPIO_OFF_P6_LATCH:
        rdata_d[PINS-1:0] = (port_six_direction_bits_q & port_six_latch_q) // RULE9
                          | (~port_six_direction_bits_q & p6_level); // RULE10
      `EPIO_OFF_P5_DIR: rdata_d[PINS-1:0] = `EPIO_WO_READ; // RULE16
      `EPIO_OFF_P6_DIR: rdata_d[PINS-1:0] = `EPIO_WO_READ; // RULE13
      `EPIO_OFF_P5_PULLUP: rdata_d[PINS-1:0] = port_five_pullup_enable_q;
      `EPIO_OFF_PWR_MODE: rdata_d[2:0] = pwr_q;
      default: rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_q <= 32'h0;
    end
    else if (avs_read && wait_q)
    begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // pull-up wanted only on inputs; float keeps pulled pins high via the pull-up
  assign p5_pu_d = ~port_five_direction_q & port_five_pullup_enable_q; // RULE6

  // pad drive: hold mode freezes the last driven state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      p5_out_q <= '0; // RULE4
      p5_oe_q <= '0;
      p5_pu_q <= '0; // RULE7
      p6_out_q <= '0;
      p6_oe_q <= '0;
    end
    else
    begin
      unique case (pwr_eff)
        EPIO_PWR_RUN:
        begin
          p5_out_q <= port_five_latch_q; // RULE1
          p5_oe_q <= port_five_direction_q; // RULE1
          p5_pu_q <= p5_pu_d; // RULE6
          p6_out_q <= port_six_latch_q; // RULE12
          p6_oe_q <= port_six_direction_bits_q; // RULE12
        end
        EPIO_PWR_HOLD:
        begin
          p5_out_q <= p5_out_q; // RULE18
        end
        EPIO_PWR_OFF:
        begin
          p5_oe_q <= '0; // RULE4
          p6_oe_q <= '0; // RULE4
          p5_pu_q <= p5_pu_d; // RULE5
        end
      endcase
    end
  end

  // side inputs stay connected whatever the direction
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_q <= '0;
      tmr_q <= 1'b0;
      adt_q <= 1'b0;
    end
    else
    begin
      irq_q <= p5_level; // RULE1
      tmr_q <= p5_level[`EPIO_BIT_TIMER]; // RULE2
      adt_q <= p5_level[`EPIO_BIT_ADTRIG]; // RULE3
    end
  end

  // pads and side outputs, all from flip-flops
  assign p5_pad_out = p5_out_q; // RULE17
  assign p5_pad_oe = p5_oe_q;
  assign p5_pad_pullup = p5_pu_q;
  assign p6_pad_out = p6_out_q;
  assign p6_pad_oe = p6_oe_q;
  assign ext_irq_level = irq_q;
  assign timer_b_event_input = tmr_q;
  assign converter_trigger_input = adt_q;

  chk_pullup_outputs_off: assert property (@(posedge clk) disable iff (!reset_n)
    (p5_pu_q & p5_oe_q) == '0) else $error("pull-up on while pin driven"); // RULE6
  chk_p6_dir_ones: assert property (@(posedge clk) disable iff (!reset_n)
    (avs_read && wait_q && avs_address == `EPIO_OFF_P6_DIR)
    |=> avs_readdata == 32'h0000_00ff) else $error("port six direction read not ones"); // RULE13
  chk_p5_dir_ones: assert property (@(posedge clk) disable iff (!reset_n)
    (avs_read && wait_q && avs_address == `EPIO_OFF_P5_DIR)
    |=> avs_readdata == 32'h0000_00ff) else $error("port five direction read not ones"); // RULE16
  chk_float_no_drive: assert property (@(posedge clk) disable iff (!reset_n)
    (pwr_eff == EPIO_PWR_OFF) |=> (p5_oe_q == '0 && p6_oe_q == '0))
    else $error("pins driven in float mode"); // RULE4
  chk_hold_freezes: assert property (@(posedge clk) disable iff (!reset_n)
    (pwr_eff == EPIO_PWR_HOLD) |=> ($stable(p5_pad_out) && $stable(p6_pad_oe)))
    else $error("pins changed in hold mode"); // RULE18
  chk_p6_read_mix: assert property (@(posedge clk) disable iff (!reset_n)
    (avs_read && wait_q && avs_address == `EPIO_OFF_P6_LATCH)
    |=> avs_readdata[7:0] == (($past(port_six_direction_bits_q) & $past(port_six_latch_q))
      | (~$past(port_six_direction_bits_q) & $past(p6_level))))
    else $error("port six read mix wrong"); // RULE9
  chk_run_drive: assert property (@(posedge clk) disable iff (!reset_n)
    (pwr_eff == EPIO_PWR_RUN) ##1 (pwr_eff == EPIO_PWR_RUN)
    |-> p6_pad_oe == $past(port_six_direction_bits_q))
    else $error("port six enable not following direction"); // RULE12
  chk_timer_follows: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 timer_b_event_input == $past(p5_level[`EPIO_BIT_TIMER]))
    else $error("timer input not following pin six"); // RULE2
  chk_trigger_follows: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 converter_trigger_input == $past(p5_level[`EPIO_BIT_ADTRIG]))
    else $error("trigger input not following pin five"); // RULE3
  chk_wait_one: assert property (@(posedge clk) disable iff (!reset_n)
    ($rose(avs_read) || $rose(avs_write)) && wait_q |=> !avs_waitrequest)
    else $error("answer not given after one wait cycle");
endmodule : epio_ports

// ===== epio_ports_tb.sv
// self-checking bench for the port five/six block
`timescale 1ns/1ps
`include "epio_cfg.svh"
module epio_ports_tb
  import epio_pkg::*;
;
  logic clk;
  logic reset_n;
  logic [15:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] pwr_mode;
  epio_byte_t p5_pad_in, p5_pad_out, p5_pad_oe, p5_pad_pullup;
  epio_byte_t p6_pad_in, p6_pad_out, p6_pad_oe, ext_irq_level;
  logic timer_b_event_input;
  logic converter_trigger_input;
  int fail_count;
  int samples_checked;
  epio_byte_t l5, d5, u5, l6, d6, r5, r6, pin5, pin6, rd;

  epio_ports #(.PINS(8)) i_dut (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pwr_mode(pwr_mode),
    .p5_pad_in(p5_pad_in), .p5_pad_out(p5_pad_out), .p5_pad_oe(p5_pad_oe),
    .p5_pad_pullup(p5_pad_pullup), .p6_pad_in(p6_pad_in), .p6_pad_out(p6_pad_out),
    .p6_pad_oe(p6_pad_oe), .ext_irq_level(ext_irq_level),
    .timer_b_event_input(timer_b_event_input),
    .converter_trigger_input(converter_trigger_input)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one avalon access: the request stands until waitrequest is sampled low at a rising edge;
  // only the watchdog ends a wait that never finishes
  task automatic bus(input logic wr, input logic [15:0] a, input epio_byte_t wd,
                     output epio_byte_t d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'($urandom()), wd};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge clk);
    end
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // one idle edge so the next call never reassigns the strobes in this time step
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [15:0] a, input epio_byte_t v);
    bus(1'b1, a, v, rd);
  endtask : wr

  task automatic rdchk(input string what, input logic [15:0] a, input epio_byte_t exp);
    epio_byte_t v;
    bus(1'b0, a, 8'h00, v);
    check(what, exp, v);
  endtask : rdchk

  // pads see the driven level on output pins, a free level on inputs
  task automatic program_ports();
    wr(`EPIO_OFF_P5_LATCH, l5);
    wr(`EPIO_OFF_P5_DIR, d5);
    wr(`EPIO_OFF_P5_PULLUP, u5);
    wr(`EPIO_OFF_P6_LATCH, l6);
    wr(`EPIO_OFF_P6_DIR, d6);
    pin5 = (d5 & l5) | (~d5 & r5);
    pin6 = (d6 & l6) | (~d6 & r6);
    p5_pad_in <= pin5;
    p6_pad_in <= pin6;
    repeat (8) @(posedge clk);
  endtask : program_ports

  // latches are read with every direction bit set, so the pads cannot mask them
  task automatic reset_checks();
    rdchk("p6 dir", `EPIO_OFF_P6_DIR, 8'hff);
    rdchk("p5 dir", `EPIO_OFF_P5_DIR, 8'hff);
    rdchk("p5 pullup reg", `EPIO_OFF_P5_PULLUP, 8'h00);
    check("p5 pullup", 8'h00, p5_pad_pullup);
    check("p6 oe", 8'h00, p6_pad_oe);
    check("p5 oe", 8'h00, p5_pad_oe);
    wr(`EPIO_OFF_P6_DIR, 8'hff);
    wr(`EPIO_OFF_P5_DIR, 8'hff);
    rdchk("p6 latch", `EPIO_OFF_P6_LATCH, 8'h00);
    rdchk("p5 latch", `EPIO_OFF_P5_LATCH, 8'h00);
    wr(`EPIO_OFF_P6_DIR, 8'h00);
    wr(`EPIO_OFF_P5_DIR, 8'h00);
  endtask : reset_checks

  task automatic port_checks();
    check("p5 oe", d5, p5_pad_oe);
    check("p5 out", d5 & l5, p5_pad_out & d5);
    check("p5 pullup", ~d5 & u5, p5_pad_pullup);
    check("irq level", pin5, ext_irq_level);
    check("timer in", {7'h00, pin5[6]}, {7'h00, timer_b_event_input});
    check("trigger in", {7'h00, pin5[5]}, {7'h00, converter_trigger_input});
    check("p6 oe", d6, p6_pad_oe);
    check("p6 out", d6 & l6, p6_pad_out & d6);
    rdchk("p5 read", `EPIO_OFF_P5_LATCH, pin5);
    rdchk("p6 read", `EPIO_OFF_P6_LATCH, pin6);
    rdchk("p5 pullup reg", `EPIO_OFF_P5_PULLUP, u5);
    rdchk("p6 dir", `EPIO_OFF_P6_DIR, 8'hff);
  endtask : port_checks

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end

  initial
  begin
    reset_n = 1'b0;
    avs_address = 16'h0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h1;
    pwr_mode = 2'h0;
    p5_pad_in = 8'h00;
    p6_pad_in = 8'h00;
    fail_count = 0;
    samples_checked = 0;
    void'($urandom(75233));
    repeat (2) @(posedge clk);
    check("oe in reset", 8'h00, p5_pad_oe | p6_pad_oe);
    reset_n <= 1'b1;
    @(posedge clk);
    reset_checks();
    // first two passes pin every direction bit to one extreme
    for (int i = 0; i < 24; i++)
    begin
      l5 = 8'($urandom());
      u5 = 8'($urandom());
      l6 = 8'($urandom());
      r5 = 8'($urandom());
      r6 = 8'($urandom());
      d5 = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom());
      d6 = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom());
      program_ports();
      port_checks();
    end
    l5 = 8'ha5;
    d5 = 8'h0f;
    u5 = 8'hff;
    l6 = 8'h5a;
    d6 = 8'h3c;
    program_ports();
    pwr_mode <= 2'h1;
    @(posedge clk);
    wr(`EPIO_OFF_P5_LATCH, 8'h5a);
    wr(`EPIO_OFF_P5_DIR, 8'hf0);
    wr(`EPIO_OFF_P6_DIR, 8'hc3);
    repeat (8) @(posedge clk);
    check("hold p5 oe", 8'h0f, p5_pad_oe);
    check("hold p5 out", 8'h05, p5_pad_out & 8'h0f);
    check("hold p6 oe", 8'h3c, p6_pad_oe);
    for (int m = 2; m < 4; m++)
    begin
      pwr_mode <= 2'(m);
      repeat (3) @(posedge clk);
      check("float oe", 8'h00, p5_pad_oe | p6_pad_oe);
      check("float pullup", 8'h0f, p5_pad_pullup);
    end
    pwr_mode <= 2'h0;
    repeat (3) @(posedge clk);
    check("run p5 oe", 8'hf0, p5_pad_oe);
    check("run p6 oe", 8'hc3, p6_pad_oe);
    // the power-mode register asks for float and run on its own
    wr(`EPIO_OFF_PWR_MODE, 8'h02);
    rdchk("pwr reg float", `EPIO_OFF_PWR_MODE, 8'h04);
    check("reg float oe", 8'h00, p5_pad_oe | p6_pad_oe);
    wr(`EPIO_OFF_PWR_MODE, 8'h00);
    rdchk("pwr reg run", `EPIO_OFF_PWR_MODE, 8'h01);
    check("reg run p5 oe", 8'hf0, p5_pad_oe);
    wr(16'hffd0, 8'h77);
    rdchk("unmapped", 16'hffd0, 8'h00);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    reset_checks();
    complete_run();
  end
endmodule : epio_ports_tb

// ===== epio_sync.sv
// three-stage pad input synchroniser with second/third agreement filter
`timescale 1ns/1ps
module epio_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pads in, clean levels out
  input wire logic [WIDTH-1:0] pad_in,
  output logic [WIDTH-1:0] level
);
  initial
  begin
    if (WIDTH < 1)
    begin
      $error("epio_sync width must be at least one");
    end
  end

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= pad_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit only changes once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          level_q[g] <= 1'b0;
        end
        else if (s2_q[g] == s3_q[g])
        begin
          level_q[g] <= s3_q[g];
        end
      end
    end
  endgenerate

  assign level = level_q;
endmodule : epio_sync
